// [qrv_defs.svh]
`ifndef QRV_DEFS_SVH
`define QRV_DEFS_SVH

// ============================================================
// Clock and widths
// ============================================================
`define QRV_CLK_HZ          200000000
`define QRV_CLK_PERIOD_PS   5000
`define QRV_CNT_W           14
`define QRV_CMD_W           10
`define QRV_ANA_W           12
`define QRV_DLY_W           3
`define QRV_LFSR_W          8

// ============================================================
// Switching windows, frequencies in Hz, times in ns
// ============================================================
`define QRV_TOUT_HZ         21500
`define QRV_TOUT_CYC        (`QRV_CLK_HZ / `QRV_TOUT_HZ)
`define QRV_BNK_FMAX_HZ     125000
`define QRV_BNK_FMAX_CYC    ((`QRV_CLK_HZ + `QRV_BNK_FMAX_HZ - 1) / `QRV_BNK_FMAX_HZ)
`define QRV_BNK_FMIN_HZ     24000
`define QRV_BNK_FMIN_CYC    ((`QRV_CLK_HZ + `QRV_BNK_FMIN_HZ - 1) / `QRV_BNK_FMIN_HZ)
`define QRV_LEB_NS          300
`define QRV_LEB_CYC         ((`QRV_LEB_NS * 1000 + `QRV_CLK_PERIOD_PS - 1) / `QRV_CLK_PERIOD_PS)

// ============================================================
// Feedback thresholds in mV, sense currents in uA
// ============================================================
`define QRV_HL_FB_HI_MV     12'h960
`define QRV_HL_FB_LO_MV     12'h7D0
`define QRV_LL_FB_HI_MV     12'h7D0
`define QRV_LL_FB_LO_MV     12'h640
`define QRV_FB_SPAN_MV      400
`define QRV_HL_ENTRY_UA     12'h5A0
`define QRV_LL_ENTRY_UA     12'h546

// ============================================================
// Reset values
// ============================================================
`define QRV_ICMD_RST        10'h3FF
`define QRV_LFSR_RST        8'hA5

`endif

// [qrv_pkg.sv]
`include "qrv_defs.svh"

package qrv_pkg;

    // ============================================================
    // Switching phases of one cycle
    // ============================================================
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ON,
        ST_BLANK,
        ST_HUNT,
        ST_DITHER
    } qrv_phase_t;

    // Whole state of the switching core.
    typedef struct packed {
        qrv_phase_t                 st;
        logic [`QRV_CNT_W-1:0]      cnt;
        logic [`QRV_CMD_W-1:0]      ramp;
        logic [`QRV_CMD_W-1:0]      icmd;
        logic                       zc_prev;
        logic                       gate;
        logic [`QRV_DLY_W-1:0]      dly;
        logic [`QRV_LFSR_W-1:0]     lfsr;
    } qrv_core_t;

    // Whole state of the blanking curve selector.
    typedef struct packed {
        logic                       line_high;
        logic [`QRV_CNT_W-1:0]      blank_cnt;
    } qrv_curve_t;

endpackage

// [qrv_blank_curve.sv]
`timescale 1ns/1ps
`include "qrv_defs.svh"

module qrv_blank_curve
    import qrv_pkg::*;
#(
    parameter int unsigned BNK_MIN_CYC = `QRV_BNK_FMIN_CYC
) (
    // Clock and reset.
    input  wire logic                   mclk_i,
    input  wire logic                   rst_b_i,
    // Line and load sensing.
    input  wire logic                   sample_i,
    input  wire logic [`QRV_ANA_W-1:0]  isense_ua_i,
    input  wire logic [`QRV_ANA_W-1:0]  fb_mv_i,
    // Selected curve.
    output logic                        line_high_o,
    output logic [`QRV_CNT_W-1:0]       blank_cnt_o
);

    // ============================================================
    // Curve shape
    // ============================================================
    localparam logic [`QRV_CNT_W-1:0] FMAX_L = `QRV_CNT_W'(`QRV_BNK_FMAX_CYC);
    localparam logic [`QRV_CNT_W-1:0] FMIN_L = BNK_MIN_CYC[`QRV_CNT_W-1:0];
    localparam int unsigned           SLOPE  = ((BNK_MIN_CYC - `QRV_BNK_FMAX_CYC) * 256) / `QRV_FB_SPAN_MV;

    qrv_curve_t cur_r;
    qrv_curve_t cur_nxt;

    // Blanking count for one curve: ceiling above hi, floor below lo, linear between.
    function automatic logic [`QRV_CNT_W-1:0] curve_cnt(input logic [`QRV_ANA_W-1:0] fb,
                                                         input logic [`QRV_ANA_W-1:0] lo,
                                                         input logic [`QRV_ANA_W-1:0] hi);
        logic [`QRV_ANA_W-1:0] d;
        logic [31:0]           prod;
        d    = fb - lo;
        prod = 32'(d) * 32'(SLOPE);
        if (fb >= hi) begin
            curve_cnt = FMAX_L;
        end else if (fb < lo) begin
            curve_cnt = FMIN_L;
        end else begin
            curve_cnt = FMIN_L - prod[8 +: `QRV_CNT_W];
        end
    endfunction

    // Line state with hysteresis, judged only while the switch conducts.
    always_comb begin
        cur_nxt = cur_r;
        if (sample_i) begin
            if (!cur_r.line_high && isense_ua_i > `QRV_HL_ENTRY_UA) begin
                cur_nxt.line_high = 1'b1;
            end else if (cur_r.line_high && isense_ua_i < `QRV_LL_ENTRY_UA) begin
                cur_nxt.line_high = 1'b0;
            end
        end
        if (cur_r.line_high) begin
            cur_nxt.blank_cnt = curve_cnt(fb_mv_i, `QRV_HL_FB_LO_MV, `QRV_HL_FB_HI_MV);
        end else begin
            cur_nxt.blank_cnt = curve_cnt(fb_mv_i, `QRV_LL_FB_LO_MV, `QRV_LL_FB_HI_MV);
        end
    end

    // State register.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cur_r <= '{line_high: 1'b0, blank_cnt: FMIN_L};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign line_high_o = cur_r.line_high;
    assign blank_cnt_o = cur_r.blank_cnt;

    // ============================================================
    // Checks
    // ============================================================
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    line_hold_off_a: assert property (!sample_i |=> $stable(line_high_o))
        else $error("Line state moved while the switch was off.");
    high_entry_a: assert property (sample_i && !line_high_o && isense_ua_i > `QRV_HL_ENTRY_UA |=> line_high_o)
        else $error("High line not entered above the entry current.");
    low_entry_a: assert property (sample_i && line_high_o && isense_ua_i < `QRV_LL_ENTRY_UA |=> !line_high_o)
        else $error("Low line not entered below the entry current.");
    heavy_ceiling_a: assert property (line_high_o && fb_mv_i >= `QRV_HL_FB_HI_MV && $stable(line_high_o)
                                      |=> blank_cnt_o == FMAX_L)
        else $error("Heavy load at high line did not give the ceiling frequency.");

endmodule

// [qrv_switch_core.sv]
`timescale 1ns/1ps
`include "qrv_defs.svh"

// How it works
// - A valley is a falling zero crossing of the aux sense input, nothing else.
// - Turn on at once from idle when run_i is set; otherwise only after blanking expires and a zero-crossing event, or a time-out with the sense input low, is seen.
// - A time-out window of 21.5 kHz bounds the lowest switching frequency unless the sense input stays high past it.
// - High line, feedback above 2.4 V: blanking frequency held at 125 kHz.
// - High line, feedback 2.0 to 2.4 V: blanking frequency follows feedback.
// - High line, feedback below 2.0 V: blanking frequency held at 24 kHz.
// - Low line switches to high line when sensed current exceeds 1.440 mA.
// - High line returns to low line when sensed current drops below 1.350 mA.
// - Line current is judged only while the switch conducts.
// - Either loop comparator tripping on the ramp ends the gate pulse.
// - Voltage loop sets duty in CV; current command saturates high; reversed in CC.
// - Current command comes from comparing estimated output current with a reference.
// - Current limit is masked for 300 ns after every turn-on.
// - Turn-on instant is dithered after the valley at both line levels.
// - After time-out, wait until the sense input has fallen before turning on.

module qrv_switch_core
    import qrv_pkg::*;
#(
    parameter int unsigned TOUT_CYC    = `QRV_TOUT_CYC,
    parameter int unsigned BNK_MIN_CYC = `QRV_BNK_FMIN_CYC
) (
    // Clock and reset.
    input  wire logic                   mclk_i,
    input  wire logic                   rst_b_i,
    // Run control.
    input  wire logic                   run_i,
    // Sense and feedback, digitised.
    input  wire logic                   aux_sense_input_i,
    input  wire logic [`QRV_ANA_W-1:0]  sense_current_ua_i,
    input  wire logic [`QRV_ANA_W-1:0]  feedback_input_mv_i,
    input  wire logic                   current_limit_i,
    // Loop commands and output current estimate.
    input  wire logic [`QRV_CMD_W-1:0]  voltage_loop_command_i,
    input  wire logic [`QRV_CMD_W-1:0]  current_estimate_i,
    input  wire logic [`QRV_CMD_W-1:0]  current_reference_i,
    // Gate drive and status.
    output logic                        gate_o,
    output logic                        line_high_o,
    output logic [`QRV_CMD_W-1:0]       current_loop_command_o
);

    // ============================================================
    // Constants at counter and command width
    // ============================================================
    localparam logic [`QRV_CNT_W-1:0] TOUT_L = TOUT_CYC[`QRV_CNT_W-1:0];
    localparam logic [`QRV_CNT_W-1:0] LEB_L  = `QRV_CNT_W'(`QRV_LEB_CYC);
    localparam logic [`QRV_CNT_W-1:0] CNT_MX = {`QRV_CNT_W{1'b1}};
    localparam logic [`QRV_CMD_W-1:0] CMD_MX = {`QRV_CMD_W{1'b1}};

    qrv_core_t               core_r;
    qrv_core_t               core_nxt;
    logic [`QRV_CNT_W-1:0]   blank_cnt;
    logic                    zc_fall;
    logic                    leb_over;
    logic                    vloop_trip;
    logic                    iloop_trip;
    logic                    end_pulse;

    // ============================================================
    // Blanking curve and line state
    // ============================================================
    qrv_blank_curve #(
        .BNK_MIN_CYC (BNK_MIN_CYC)
    ) u_curve (
        .mclk_i      (mclk_i),
        .rst_b_i     (rst_b_i),
        .sample_i    (core_r.gate),
        .isense_ua_i (sense_current_ua_i),
        .fb_mv_i     (feedback_input_mv_i),
        .line_high_o (line_high_o),
        .blank_cnt_o (blank_cnt)
    );

    // ============================================================
    // Turn-on and turn-off conditions
    // ============================================================

    // Valley event: sense was above zero last cycle and is below now.
    assign zc_fall    = core_r.zc_prev && !aux_sense_input_i;
    // Current limit counts only after the leading-edge mask has run out.
    assign leb_over   = core_r.cnt >= LEB_L;
    // Each loop comparator trips when the ramp reaches its command.
    assign vloop_trip = core_r.ramp >= voltage_loop_command_i;
    assign iloop_trip = core_r.ramp >= core_r.icmd;
    assign end_pulse  = vloop_trip || iloop_trip || (current_limit_i && leb_over);

    // ============================================================
    // Next state
    // ============================================================
    always_comb begin
        core_nxt         = core_r;
        core_nxt.zc_prev = aux_sense_input_i;
        core_nxt.lfsr    = {core_r.lfsr[`QRV_LFSR_W-2:0],
                            core_r.lfsr[7] ^ core_r.lfsr[5] ^ core_r.lfsr[4] ^ core_r.lfsr[3]};
        // Interval counter runs from turn-on and saturates.
        if (core_r.cnt != CNT_MX) begin
            core_nxt.cnt = core_r.cnt + `QRV_CNT_W'(1);
        end
        unique case (core_r.st)
            ST_IDLE: begin
                core_nxt.gate = 1'b0;
                if (run_i) begin
                    core_nxt.st   = ST_ON;
                    core_nxt.gate = 1'b1;
                    core_nxt.cnt  = '0;
                    core_nxt.ramp = '0;
                end
            end
            ST_ON: begin
                if (core_r.ramp != CMD_MX) begin
                    core_nxt.ramp = core_r.ramp + `QRV_CMD_W'(1);
                end
                if (!run_i) begin
                    core_nxt.st   = ST_IDLE;
                    core_nxt.gate = 1'b0;
                end else if (end_pulse) begin
                    core_nxt.st   = ST_BLANK;
                    core_nxt.gate = 1'b0;
                    // Current command steps down while the estimate exceeds the reference, else up, once per cycle.
                    if (current_estimate_i > current_reference_i) begin
                        if (core_r.icmd != '0) begin
                            core_nxt.icmd = core_r.icmd - `QRV_CMD_W'(1);
                        end
                    end else if (core_r.icmd != CMD_MX) begin
                        core_nxt.icmd = core_r.icmd + `QRV_CMD_W'(1);
                    end
                end
            end
            ST_BLANK: begin
                // No valley is taken until the blanking count is reached.
                if (core_r.cnt >= blank_cnt) begin
                    core_nxt.st = ST_HUNT;
                end
            end
            ST_HUNT: begin
                // A fresh valley, or a sense input already low after time-out.
                if (zc_fall || (core_r.cnt >= TOUT_L && !aux_sense_input_i)) begin
                    core_nxt.st  = ST_DITHER;
                    core_nxt.dly = core_r.lfsr[`QRV_DLY_W-1:0];
                end
            end
            ST_DITHER: begin
                // Pseudo-random delay shifts the turn-on instant.
                if (core_r.dly == '0) begin
                    core_nxt.st   = run_i ? ST_ON : ST_IDLE;
                    core_nxt.gate = run_i;
                    core_nxt.cnt  = '0;
                    core_nxt.ramp = '0;
                end else begin
                    core_nxt.dly = core_r.dly - `QRV_DLY_W'(1);
                end
            end
            default: begin
                core_nxt.st   = ST_IDLE;
                core_nxt.gate = 1'b0;
            end
        endcase
    end

    // State register.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            core_r <= '{st: ST_IDLE, cnt: '0, ramp: '0, icmd: `QRV_ICMD_RST, zc_prev: 1'b0,
                        gate: 1'b0, dly: '0, lfsr: `QRV_LFSR_RST};
        end else begin
            core_r <= core_nxt;
        end
    end

    // Outputs straight from the state register.
    assign gate_o                 = core_r.gate;
    assign current_loop_command_o = core_r.icmd;

    // ============================================================
    // Checks
    // ============================================================
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    // Valley search left with a dither delay loaded.
    sequence s_valley_taken;
        core_r.st == ST_HUNT ##1 core_r.st == ST_DITHER;
    endsequence

    // Gate raised out of the dither phase.
    sequence s_gate_rise;
        core_r.st == ST_DITHER && run_i && core_r.dly == '0 ##1 gate_o && core_r.cnt == '0;
    endsequence

    valley_edge_a: assert property (s_valley_taken |-> $past(zc_fall, 1) ||
                                    ($past(core_r.cnt, 1) >= TOUT_L && !$past(aux_sense_input_i, 1)))
        else $error("Valley taken without a falling crossing or time-out.");
    blank_hold_a: assert property (core_r.st == ST_BLANK && core_r.cnt < blank_cnt |=> core_r.st == ST_BLANK)
        else $error("Blanking left before its count.");
    gate_from_valley_a: assert property ($rose(gate_o) |-> $past(core_r.st, 1) == ST_DITHER ||
                                         $past(core_r.st, 1) == ST_IDLE)
        else $error("Gate rose outside a turn-on decision.");
    timeout_turn_a: assert property (core_r.st == ST_HUNT && core_r.cnt >= TOUT_L && !aux_sense_input_i
                                     |=> core_r.st == ST_DITHER)
        else $error("Time-out expiry with sense low did not start turn-on.");
    ccm_wait_a: assert property (core_r.st == ST_HUNT && aux_sense_input_i |=> core_r.st == ST_HUNT)
        else $error("Turn-on started while sense was still high.");
    leb_mask_a: assert property (core_r.st == ST_ON && run_i && !leb_over && !vloop_trip && !iloop_trip
                                 |=> gate_o)
        else $error("Pulse ended inside the leading-edge mask.");
    limit_ends_a: assert property (core_r.st == ST_ON && run_i && leb_over && current_limit_i |=> !gate_o)
        else $error("Current limit after the mask did not end the pulse.");
    vloop_ends_a: assert property (core_r.st == ST_ON && run_i && vloop_trip |=> !gate_o ##1 !gate_o)
        else $error("Voltage loop trip did not end the pulse.");
    iloop_rise_a: assert property (core_r.st == ST_ON && run_i && end_pulse && core_r.icmd != CMD_MX &&
                                   current_estimate_i <= current_reference_i
                                   |=> core_r.icmd == $past(core_r.icmd) + `QRV_CMD_W'(1))
        else $error("Current command did not rise with estimate under reference.");
    dither_bound_a: assert property (s_valley_taken ##0 run_i[*8] |-> ##[0:7] gate_o)
        else $error("Dither delay exceeded its range.");
    restart_a: assert property (s_gate_rise |-> core_r.ramp == '0)
        else $error("Counters not restarted at turn-on.");

endmodule

// [qrv_flyback_model.sv]
`timescale 1ns/1ps
`include "qrv_defs.svh"

// ============================================================
// Flyback power stage as seen from the controller pins
// ============================================================
module qrv_flyback_model (
    // Clock.
    input  wire logic                   mclk_i,
    // Gate drive from the controller.
    input  wire logic                   gate_i,
    // Behaviour set by the bench.
    input  wire logic                   ring_i,
    input  wire logic [15:0]            hold_cyc_i,
    input  wire logic [`QRV_ANA_W-1:0]  on_ua_i,
    input  wire logic [`QRV_ANA_W-1:0]  off_ua_i,
    // Sense pin as digitised for the controller.
    output logic                        aux_sense_o,
    output logic [`QRV_ANA_W-1:0]       sense_ua_o
);
    logic [15:0] off_cnt_r = 16'h0000;

    // Counts cycles since the switch stopped conducting.
    always_ff @(posedge mclk_i) begin
        if (gate_i) begin
            off_cnt_r <= 16'h0000;
        end else if (off_cnt_r != 16'hFFFF) begin
            off_cnt_r <= off_cnt_r + 16'h0001;
        end
    end

    // Winding is negative while on; after turn-off it either rings with a
    // 32-cycle period or stays high for hold_cyc_i cycles and then drops.
    // Off-time current differs from on-time current so mis-sampling shows.
    assign aux_sense_o = gate_i ? 1'b0 : (ring_i ? ~off_cnt_r[4] : (off_cnt_r < hold_cyc_i));
    assign sense_ua_o  = gate_i ? on_ua_i : off_ua_i;
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "qrv_defs.svh"

module tb_top;
    // ============================================================
    // Stimulus and wiring
    // ============================================================
    localparam int TOUT = 3000;
    localparam int BNK  = 2000;
    localparam int BMAX = `QRV_BNK_FMAX_CYC;
    logic                   mclk_i   = 1'b0;
    logic                   rst_b_i  = 1'b0;
    logic                   run_i    = 1'b1;
    logic                   climit   = 1'b0;
    logic                   ring     = 1'b1;
    logic [15:0]            hold     = 16'h0032;
    logic [`QRV_ANA_W-1:0]  fb_mv    = 12'h3E8;
    logic [`QRV_ANA_W-1:0]  on_ua    = 12'h000;
    logic [`QRV_ANA_W-1:0]  off_ua   = 12'h000;
    logic [`QRV_CMD_W-1:0]  vcmd     = 10'h3FF;
    logic [`QRV_CMD_W-1:0]  est      = 10'h005;
    logic [`QRV_CMD_W-1:0]  iref     = 10'h000;
    logic                   aux_w;
    logic [`QRV_ANA_W-1:0]  isense_w;
    logic                   gate_o;
    logic                   line_high_o;
    logic [`QRV_CMD_W-1:0]  icmd_o;
    int                     n_errors  = 0;
    int                     tests_run = 0;

    // Clock of 5 ns period.
    always #2.5 mclk_i = ~mclk_i;

    qrv_switch_core #(.TOUT_CYC(TOUT), .BNK_MIN_CYC(BNK)) uut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .run_i(run_i), .aux_sense_input_i(aux_w),
        .sense_current_ua_i(isense_w), .feedback_input_mv_i(fb_mv), .current_limit_i(climit),
        .voltage_loop_command_i(vcmd), .current_estimate_i(est), .current_reference_i(iref),
        .gate_o(gate_o), .line_high_o(line_high_o), .current_loop_command_o(icmd_o));

    qrv_flyback_model stage (
        .mclk_i(mclk_i), .gate_i(gate_o), .ring_i(ring), .hold_cyc_i(hold), .on_ua_i(on_ua),
        .off_ua_i(off_ua), .aux_sense_o(aux_w), .sense_ua_o(isense_w));

    // ============================================================
    // Shared tasks
    // ============================================================
    task automatic wrap_up();
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    // Counts edges until the gate shows the wanted level; bounded.
    task automatic wait_gate(input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge mclk_i);
            #1;
            n++;
            if (n > 20000) begin
                n_errors++;
                $display("mismatch at %0t: got %h expected %h", $time, gate_o, lvl);
                wrap_up();
            end
        end while (gate_o !== lvl);
    endtask

    // Pulse width and whole period, measured from one observed turn-on.
    task automatic period(output int w, output int p);
        int off;
        wait_gate(1'b0, w);
        wait_gate(1'b1, off);
        p = w + off;
    endtask

    // Expected blanking count from the load curve of each line level.
    function automatic int exp_blank(input int fb, input bit hi);
        int lo_mv;
        lo_mv = hi ? 2000 : 1600;
        if (fb >= lo_mv + 400) return BMAX;
        if (fb < lo_mv) return BNK;
        return BNK - (((fb - lo_mv) * (((BNK - BMAX) * 256) / 400)) >> 8);
    endfunction

    // ============================================================
    // Scenarios
    // ============================================================
    task automatic s_reset();
        rst_b_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        #1;
        chk(16'(gate_o), 16'h0000);
        chk(16'(line_high_o), 16'h0000);
        chk(16'(icmd_o), 16'h03FF);
    endtask

    // Current loop takes over the duty when the estimate runs high, and
    // recovers once the estimate drops below the reference.
    task automatic s_cc();
        int w;
        int n;
        wait_gate(1'b1, n);
        wait_gate(1'b0, w);
        chk_rng(w, 1024, 1024);
        chk(16'(icmd_o), 16'h03FE);
        wait_gate(1'b1, n);
        wait_gate(1'b0, w);
        chk_rng(w, 1023, 1023);
        est  <= 10'h000;
        iref <= 10'h005;
        wait_gate(1'b1, n);
        wait_gate(1'b0, w);
        chk_rng(w, 1022, 1022);
        chk(16'(icmd_o), 16'h03FE);
    endtask

    // Voltage loop sets duty; current command saturates at full scale.
    task automatic s_width();
        int w;
        int n;
        iref <= 10'h000;
        vcmd <= 10'h014;
        wait_gate(1'b1, n);
        wait_gate(1'b0, w);
        chk_rng(w, 21, 21);
        wait_gate(1'b1, n);
        wait_gate(1'b0, w);
        chk(16'(icmd_o), 16'h03FF);
    endtask

    // A limit trip held from turn-on ends the pulse only after the mask.
    task automatic s_leb();
        int w;
        int n;
        vcmd   <= 10'h3FF;
        climit <= 1'b1;
        wait_gate(1'b1, n);
        wait_gate(1'b0, w);
        chk_rng(w, `QRV_LEB_CYC + 1, `QRV_LEB_CYC + 1);
        vcmd   <= 10'h014;
        climit <= 1'b0;
    endtask

    task automatic line_row(input logic [11:0] on, input logic [11:0] off, input logic exp);
        int w;
        int p;
        on_ua  <= on;
        off_ua <= off;
        period(w, p);
        period(w, p);
        chk(16'(line_high_o), 16'(exp));
    endtask

    task automatic curve_row(input logic [11:0] fb, input logic [11:0] on, input bit hi);
        int w;
        int p;
        int e;
        fb_mv <= fb;
        on_ua <= on;
        e = exp_blank(int'(fb), hi);
        period(w, p);
        period(w, p);
        period(w, p);
        chk(16'(line_high_o), 16'(hi));
        chk_rng(p, e, e + 32 + 12);
    endtask

    // Valleys after blanking set the period; the turn-on instant wanders.
    task automatic s_curve();
        int w;
        int p;
        int lo;
        int hi;
        lo = 99999;
        hi = 0;
        for (int i = 0; i < 5; i++) begin
            period(w, p);
            chk_rng(p, BNK, BNK + 32 + 12);
            if (i > 0 && p < lo) lo = p;
            if (i > 0 && p > hi) hi = p;
        end
        chk_rng(hi - lo, 1, 40);
        curve_row(12'h708, 12'h000, 1'b0);
        curve_row(12'h9C4, 12'h000, 1'b0);
        curve_row(12'h9C4, 12'h5DC, 1'b1);
        curve_row(12'h898, 12'h5DC, 1'b1);
        curve_row(12'h76C, 12'h5DC, 1'b1);
        curve_row(12'h3E8, 12'h000, 1'b0);
    endtask

    // No valley after blanking: time-out, or wait for the winding to fall.
    task automatic s_timeout();
        int w;
        int p;
        ring <= 1'b0;
        period(w, p);
        period(w, p);
        chk_rng(p, TOUT, TOUT + 12);
        hold <= 16'h0E10;
        period(w, p);
        period(w, p);
        chk_rng(p, 3600 + 21, 3600 + 21 + 12);
    endtask

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        s_reset();
        s_cc();
        s_width();
        s_leb();
        line_row(12'h514, 12'h5DC, 1'b0);
        line_row(12'h5A0, 12'h000, 1'b0);
        line_row(12'h5A1, 12'h000, 1'b1);
        line_row(12'h546, 12'h000, 1'b1);
        line_row(12'h545, 12'h000, 1'b0);
        s_curve();
        s_timeout();
        wrap_up();
    end
endmodule
